// ---- src/ecp_in_filter.sv ----
// Input synchroniser, debounce filter and falling-edge detector.
`timescale 1ns/1ns
`default_nettype none
module ecp_in_filter
    import ecp_pkg::*;
#(
    parameter int WIDTH       = ECP_NPIN,
    parameter int FILT_CYCLES = ECP_FILTER_CYC
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Raw pins and filtered results.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] fall
);
    localparam int CW = $clog2(FILT_CYCLES + 1);

    if (WIDTH < 1 || FILT_CYCLES < 1)
    begin : g_bad
        $error("ecp_in_filter: WIDTH and FILT_CYCLES must be positive");
    end

    typedef struct packed {
        logic [WIDTH-1:0]         s1;
        logic [WIDTH-1:0]         s2;
        logic [WIDTH-1:0]         filt;
        logic [WIDTH-1:0]         fall;
        logic [WIDTH-1:0][CW-1:0] cnt;
    } ecp_filt_st_t;

    localparam ecp_filt_st_t FILT_RST = '{'1, '1, '1, '0, '0};

    ecp_filt_st_t q;
    ecp_filt_st_t d;

    // A level must hold for FILT_CYCLES cycles; one falling edge gives one pulse.
    always_comb
    begin
        d      = q;
        d.s1   = pin_in;
        d.s2   = q.s1;
        d.fall = '0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (q.s2[i] == q.filt[i])
                d.cnt[i] = '0;
            else if (q.cnt[i] == CW'(FILT_CYCLES - 1))
            begin
                d.cnt[i]  = '0;
                d.filt[i] = q.s2[i];
                d.fall[i] = !q.s2[i]; // RQ22
            end
            else
                d.cnt[i] = q.cnt[i] + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= FILT_RST;
        else
            q <= d;
    end

    assign level = q.filt;
    assign fall  = q.fall;

endmodule // ecp_in_filter
`default_nettype wire

// ---- src/ecp_pkg.sv ----
// Shared constants, register map and helpers of the external control port.
package ecp_pkg;

    // Register byte offsets.
    localparam logic [7:0] ECP_CTRL_OFS   = 8'h00;
    localparam logic [7:0] ECP_STATE_OFS  = 8'h04;
    localparam logic [7:0] ECP_TWIDTH_OFS = 8'h08;
    localparam logic [7:0] ECP_TCMD_OFS   = 8'h0c;
    localparam logic [7:0] ECP_EVENT_OFS  = 8'h10;
    localparam logic [7:0] ECP_PINS_OFS   = 8'h14;

    // Control register fields.
    localparam int ECP_CTRL_W        = 7;
    localparam int ECP_CTRL_MODE_LSB = 0;
    localparam int ECP_CTRL_POL_BIT  = 2;
    localparam int ECP_CTRL_TPOL_BIT = 3;
    localparam int ECP_CTRL_RMT_BIT  = 4;
    localparam int ECP_CTRL_FN_LSB   = 5;
    localparam logic [ECP_CTRL_W-1:0] ECP_CTRL_RST = 7'h00;

    // Device state register fields, written by firmware.
    localparam int ECP_ST_W       = 9;
    localparam int ECP_ST_PWR     = 0;
    localparam int ECP_ST_OUT     = 1;
    localparam int ECP_ST_PROT    = 2;
    localparam int ECP_ST_LIM     = 3;
    localparam int ECP_ST_GAIN    = 4;
    localparam int ECP_ST_BUSY    = 5;
    localparam int ECP_ST_LORANGE = 6;
    localparam int ECP_ST_SYNC    = 7;
    localparam logic [ECP_ST_W-1:0] ECP_STATE_RST = 9'h000;

    // Command and event bit positions.
    localparam int ECP_NCMD       = 9;
    localparam int ECP_NPIN       = 11;
    localparam int ECP_EV_OFF     = 0;
    localparam int ECP_EV_ON      = 1;
    localparam int ECP_EV_START   = 2;
    localparam int ECP_EV_STOP    = 3;
    localparam int ECP_EV_HOLD    = 4;
    localparam int ECP_EV_BR1     = 5;
    localparam int ECP_EV_BR2     = 6;
    localparam int ECP_EV_RECALL  = 7;
    localparam int ECP_EV_PEAK    = 8;
    localparam int ECP_EV_COMPILE = 9;
    localparam int ECP_EV_MEM_LSB = 10;
    localparam int ECP_EV_FN_LSB  = 12;
    localparam int ECP_EV_W       = 14;
    localparam logic [ECP_EV_W-1:0] ECP_EVENT_RST = 14'h0000;

    // External control settings and active functions.
    localparam logic [1:0] ECP_MODE_DISABLE = 2'h0;
    localparam logic [1:0] ECP_MODE_ENABLE  = 2'h1;
    localparam logic [1:0] ECP_MODE_TESTER  = 2'h2;
    localparam logic [1:0] ECP_FN_CONT      = 2'h0;
    localparam logic [1:0] ECP_FN_SEQ       = 2'h1;
    localparam logic [1:0] ECP_FN_SIM       = 2'h2;

    // Timing.
    localparam int ECP_CLK_HZ        = 10000000;
    localparam int ECP_TRIG_WIDTH_US = 10000;
    localparam int ECP_TRIG_WIDTH_CYC =
        ECP_TRIG_WIDTH_US * (ECP_CLK_HZ / 1000000);
    localparam int ECP_FILTER_US     = 10;
    localparam int ECP_FILTER_CYC    = ECP_FILTER_US * (ECP_CLK_HZ / 1000000);
    localparam int ECP_TW_W          = 24;

    // Applies the selectable polarity: positive passes, negative inverts.
    function automatic logic ecp_pol_f(input logic lvl, input logic pos);
        return pos ? lvl : !lvl;
    endfunction

endpackage

// ---- src/ecp_port.sv ----
// External control I/O port: command inputs, status outputs, register slave.
//
// Overview of operation
// RQ1: Three settings; disabled ignores inputs, status stays live.
// RQ2: All control inputs are ignored while remote communication is active.
// RQ3: Two memory-select inputs pick one of four setups of the function.
// RQ4: Recall falling edge loads the selected setup for the active function.
// RQ5: Recall under sequence or simulation also requests a compile.
// RQ6: Falling edges on off and on inputs switch the output.
// RQ7: Falling edges start, stop, or start branch one or two.
// RQ8: Hold input falling edge puts the running sequence on hold.
// RQ9: Peak-clear falling edge resets the held peak current.
// RQ10: One setting inverts the polarity-selectable status outputs.
// RQ11: Power-state pin is high when powered on, fixed polarity.
// RQ12: Output and gain-correction pins low-on negative, high-on positive.
// RQ13: Protection and limiter pins low-active negative, high-active positive.
// RQ14: Busy pin low-busy negative, high-busy positive.
// RQ15: Range pin low for higher range, high for lower range.
// RQ16: Step sync code drives two pins, first low bit, second high.
// RQ17: Controller should choose disabled when unused to avoid noise.
// RQ18: Port control and tester-control mode never operate together.
// RQ19: Select lines give memory one to four, first line low bit.
// RQ20: Step sync code LL, LH, HL, HH map to the two pins.
// RQ21: Trigger pin emits a pulse of set width and polarity.
// RQ22: Inputs are synchronised and filtered before falling-edge detection.
// RQ23: Trigger counter loads width and restarts on a new trigger.
`timescale 1ns/1ns
`default_nettype none
module ecp_port
    import ecp_pkg::*;
#(
    parameter int TRIG_WIDTH_RST = ECP_TRIG_WIDTH_CYC
)
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          resetn,
    // Avalon-MM slave.
    input  wire logic [7:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    // Command pins, active falling edge; memory select, sampled as a level.
    input  wire logic          out_off_n,
    input  wire logic          out_on_n,
    input  wire logic          seq_start_n,
    input  wire logic          seq_stop_n,
    input  wire logic          seq_hold_n,
    input  wire logic          branch1_n,
    input  wire logic          branch2_n,
    input  wire logic          recall_n,
    input  wire logic          peak_clear_n,
    input  wire logic [1:0]    mem_sel,
    // Status pins.
    output logic               power_state_pin,
    output logic               output_state_pin,
    output logic               protection_pin,
    output logic               limiter_pin,
    output logic               gain_correction_state_pin,
    output logic               busy_pin,
    output logic               range_pin,
    output logic [1:0]         step_sync,
    output logic               trigger_pin,
    // Command strobes to the device logic.
    output logic [9:0]         cmd_strobe,
    output logic [1:0]         recall_mem
);
    if (TRIG_WIDTH_RST < 1 || TRIG_WIDTH_RST >= (1 << ECP_TW_W))
    begin : g_bad
        $error("ecp_port: TRIG_WIDTH_RST out of range");
    end

    typedef struct packed {
        logic [ECP_CTRL_W-1:0] ctrl;
        logic [ECP_ST_W-1:0]   state;
        logic [ECP_TW_W-1:0]   twidth;
        logic [ECP_EV_W-1:0]   ev;
        logic                  wreq;
        logic [31:0]           rdata;
        logic                  tfire;
        logic [9:0]            strobe;
        logic [1:0]            rmem;
        logic [6:0]            stat;
        logic [1:0]            sync;
    } ecp_port_st_t;

    ecp_port_st_t q;
    ecp_port_st_t d;

    logic [ECP_NPIN-1:0] lvl;
    logic [ECP_NPIN-1:0] fall;
    logic                trig_active;
    logic [1:0]          mode;
    logic [1:0]          fn;
    logic                pos;
    logic                accept;
    logic                we;
    logic [31:0]         rd;
    logic [ECP_EV_W-1:0] ev_set;

    ecp_in_filter #(
        .WIDTH       (ECP_NPIN),
        .FILT_CYCLES (ECP_FILTER_CYC)
    ) u_filt (
        .clk    (clk),
        .resetn (resetn),
        .pin_in ({mem_sel, peak_clear_n, recall_n, branch2_n, branch1_n,
                  seq_hold_n, seq_stop_n, seq_start_n, out_on_n, out_off_n}),
        .level  (lvl),
        .fall   (fall)
    );

    ecp_trig_pulse #(
        .CW (ECP_TW_W)
    ) u_trig (
        .clk      (clk),
        .resetn   (resetn),
        .fire     (q.tfire),
        .width    (q.twidth),
        .pol_pos  (q.ctrl[ECP_CTRL_TPOL_BIT]),
        .trig_out (trigger_pin),
        .active   (trig_active)
    );

    assign mode = q.ctrl[ECP_CTRL_MODE_LSB +: 2];
    assign fn   = q.ctrl[ECP_CTRL_FN_LSB +: 2];
    assign pos  = q.ctrl[ECP_CTRL_POL_BIT];
    // Only the enabled setting, outside remote operation, takes commands.
    assign accept = (mode == ECP_MODE_ENABLE) // RQ1 RQ18
                    && !q.ctrl[ECP_CTRL_RMT_BIT]; // RQ2
    assign we = avs_write && !q.wreq;

    always_comb
    begin
        rd = 32'h0000_0000;
        unique case (avs_address)
            ECP_CTRL_OFS:   rd = 32'(q.ctrl);
            ECP_STATE_OFS:  rd = 32'(q.state);
            ECP_TWIDTH_OFS: rd = 32'(q.twidth);
            ECP_TCMD_OFS:   rd = 32'(trig_active);
            ECP_EVENT_OFS:  rd = 32'(q.ev);
            ECP_PINS_OFS:   rd = 32'(lvl);
            default:        rd = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        d = q;
        // One wait state: capture read data, release on the next edge.
        d.wreq = 1'b1;
        if ((avs_read || avs_write) && q.wreq)
        begin
            d.wreq  = 1'b0;
            d.rdata = rd;
        end
        // Filtered falling edges become one-cycle strobes.
        d.strobe = '0;
        if (accept)
        begin
            d.strobe[ECP_NCMD-1:0] = fall[ECP_NCMD-1:0]; // RQ6 RQ7 RQ8 RQ9
            if (fall[ECP_EV_RECALL])
            begin
                d.rmem = lvl[ECP_NPIN-1 -: 2]; // RQ3 RQ19 RQ4
                d.strobe[ECP_EV_COMPILE] = (fn != ECP_FN_CONT); // RQ5
            end
        end
        ev_set = '0;
        ev_set[9:0] = d.strobe;
        // Events are write-one-to-clear; a new event wins over the clear.
        d.ev[9:0] = q.ev[9:0] & ~((we && avs_address == ECP_EVENT_OFS)
                    ? avs_writedata[9:0] : 10'h000);
        d.ev[9:0] = d.ev[9:0] | ev_set[9:0];
        if (d.strobe[ECP_EV_RECALL])
        begin
            d.ev[ECP_EV_MEM_LSB +: 2] = d.rmem;
            d.ev[ECP_EV_FN_LSB +: 2]  = fn;
        end
        d.tfire = 1'b0;
        if (we)
        begin
            unique case (avs_address)
                ECP_CTRL_OFS:   d.ctrl   = avs_writedata[ECP_CTRL_W-1:0];
                ECP_STATE_OFS:  d.state  = avs_writedata[ECP_ST_W-1:0];
                ECP_TWIDTH_OFS: d.twidth = avs_writedata[ECP_TW_W-1:0];
                ECP_TCMD_OFS:   d.tfire  = avs_writedata[0];
                default:        d.tfire  = 1'b0;
            endcase
        end
        // Status pins stay live in every setting.
        d.stat[0] = q.state[ECP_ST_PWR]; // RQ11
        d.stat[1] = ecp_pol_f(q.state[ECP_ST_OUT], pos); // RQ10 RQ12
        d.stat[2] = ecp_pol_f(q.state[ECP_ST_PROT], pos); // RQ13
        d.stat[3] = ecp_pol_f(q.state[ECP_ST_LIM], pos); // RQ13
        d.stat[4] = ecp_pol_f(q.state[ECP_ST_GAIN], pos); // RQ12
        d.stat[5] = ecp_pol_f(q.state[ECP_ST_BUSY], pos); // RQ14
        d.stat[6] = q.state[ECP_ST_LORANGE]; // RQ15
        d.sync    = q.state[ECP_ST_SYNC +: 2]; // RQ16 RQ20
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q        <= '0;
            q.ctrl   <= ECP_CTRL_RST;
            q.state  <= ECP_STATE_RST;
            q.ev     <= ECP_EVENT_RST;
            q.twidth <= ECP_TW_W'(TRIG_WIDTH_RST);
            q.wreq   <= 1'b1;
            q.stat   <= 7'h3e;
        end
        else
            q <= d;
    end

    assign avs_readdata              = q.rdata;
    assign avs_waitrequest           = q.wreq;
    assign power_state_pin           = q.stat[0];
    assign output_state_pin          = q.stat[1];
    assign protection_pin            = q.stat[2];
    assign limiter_pin               = q.stat[3];
    assign gain_correction_state_pin = q.stat[4];
    assign busy_pin                  = q.stat[5];
    assign range_pin                 = q.stat[6];
    assign step_sync                 = q.sync;
    assign cmd_strobe                = q.strobe;
    assign recall_mem                = q.rmem;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ignore_disabled_a: assert property ( // RQ1
        (mode != ECP_MODE_ENABLE) |=> (cmd_strobe == 10'h000))
        else $error("command accepted outside enabled setting");
    ignore_remote_a: assert property ( // RQ2
        (q.ctrl[ECP_CTRL_RMT_BIT] && |fall) |=> (cmd_strobe == 10'h000))
        else $error("command accepted during remote operation");
    tester_exclusive_a: assert property ( // RQ18
        (mode == ECP_MODE_TESTER) |=> (cmd_strobe == 10'h000))
        else $error("port active in tester-control mode");
    cmd_edge_a: assert property ( // RQ6
        accept |=> (cmd_strobe[8:0] == $past(fall[8:0])))
        else $error("falling edge not turned into strobe");
    recall_select_a: assert property ( // RQ4
        (accept && fall[ECP_EV_RECALL]) |=>
            (recall_mem == $past(lvl[10:9])) && cmd_strobe[ECP_EV_RECALL])
        else $error("recall did not capture memory select");
    recall_compile_a: assert property ( // RQ5
        (accept && fall[ECP_EV_RECALL]) |=>
            (cmd_strobe[ECP_EV_COMPILE] == ($past(fn) != ECP_FN_CONT)))
        else $error("compile request wrong after recall");
    output_pol_a: assert property ( // RQ12
        ##1 (output_state_pin ==
            ($past(pos) ? $past(q.state[ECP_ST_OUT])
                        : !$past(q.state[ECP_ST_OUT]))))
        else $error("output state pin polarity wrong");
    busy_pol_a: assert property ( // RQ14
        ##1 (busy_pin == ($past(q.state[ECP_ST_BUSY]) ~^ $past(pos))))
        else $error("busy pin polarity wrong");
    range_fixed_a: assert property ( // RQ15
        $changed(q.state) |=> (range_pin == $past(q.state[ECP_ST_LORANGE]))
            && (power_state_pin == $past(q.state[ECP_ST_PWR])))
        else $error("range or power pin wrong");
    sync_code_a: assert property ( // RQ16
        ##1 (step_sync == $past(q.state[ECP_ST_SYNC +: 2])))
        else $error("step sync code pins wrong");
    event_sticky_a: assert property ( // RQ4
        cmd_strobe[ECP_EV_RECALL] |-> q.ev[ECP_EV_RECALL])
        else $error("recall event lost against clear");
    event_mem_a: assert property ( // RQ19
        cmd_strobe[ECP_EV_RECALL] |->
            (q.ev[ECP_EV_MEM_LSB +: 2] == recall_mem))
        else $error("event memory number differs from recall");
    recall_hold_a: assert property ( // RQ4
        !cmd_strobe[ECP_EV_RECALL] |-> $stable(recall_mem))
        else $error("recall memory changed without recall");
    strobe_single_a: assert property ( // RQ22
        ##1 ((cmd_strobe[8:0] & $past(cmd_strobe[8:0])) == 9'h000))
        else $error("one pin edge gave two strobes");
    power_pin_a: assert property ( // RQ11
        ##1 (power_state_pin == $past(q.state[ECP_ST_PWR])))
        else $error("power state pin wrong");
    prot_pol_a: assert property ( // RQ13
        ##1 (protection_pin == ($past(q.state[ECP_ST_PROT]) ~^ $past(pos))))
        else $error("protection pin polarity wrong");
    limiter_pol_a: assert property ( // RQ13
        ##1 (limiter_pin == ($past(q.state[ECP_ST_LIM]) ~^ $past(pos))))
        else $error("limiter pin polarity wrong");
    gain_pol_a: assert property ( // RQ12
        ##1 (gain_correction_state_pin ==
            ($past(q.state[ECP_ST_GAIN]) ~^ $past(pos))))
        else $error("gain correction pin polarity wrong");
    bus_wait_a: assert property (
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");

    recall_compile_c: cover property (
        cmd_strobe[ECP_EV_RECALL] && cmd_strobe[ECP_EV_COMPILE]);
    output_on_c: cover property (cmd_strobe[ECP_EV_ON]);
    trigger_restart_c: cover property (q.tfire && trig_active);
    remote_block_c: cover property (q.ctrl[ECP_CTRL_RMT_BIT] && |fall[8:0]);
    sim_recall_c: cover property (
        cmd_strobe[ECP_EV_RECALL] && (fn == ECP_FN_SIM));

endmodule // ecp_port
`default_nettype wire

// ---- src/ecp_trig_pulse.sv ----
// Trigger pulse generator with programmable width and polarity.
`timescale 1ns/1ns
`default_nettype none
module ecp_trig_pulse
    import ecp_pkg::*;
#(
    parameter int CW = ECP_TW_W
)
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          resetn,
    // Control.
    input  wire logic          fire,
    input  wire logic [CW-1:0] width,
    input  wire logic          pol_pos,
    // Pulse.
    output logic               trig_out,
    output logic               active
);
    if (CW < 1)
    begin : g_bad
        $error("ecp_trig_pulse: CW must be positive");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          out;
    } ecp_trig_st_t;

    ecp_trig_st_t q;
    ecp_trig_st_t d;

    // A new fire reloads the count, so a running pulse is stretched.
    always_comb
    begin
        d = q;
        if (fire)
            d.cnt = (width == '0) ? CW'(1) : width; // RQ23
        else if (q.cnt != '0)
            d.cnt = q.cnt - CW'(1);
        d.out = ecp_pol_f(d.cnt != '0, pol_pos); // RQ21
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= '{cnt: '0, out: 1'b1};
        else
            q <= d;
    end

    assign trig_out = q.out;
    assign active   = q.cnt != '0;

    restart_load_a: assert property ( // RQ23
        @(posedge clk) disable iff (!resetn)
        fire |=> q.cnt == (($past(width) == '0) ? CW'(1) : $past(width)))
        else $error("trigger count not reloaded on fire");

endmodule // ecp_trig_pulse
`default_nettype wire

// ---- verification/ecp_ctl_model.sv ----
// External controller model driving the command and memory-select pins.
`timescale 1ns/1ns
`default_nettype none
module ecp_ctl_model
(
    // Clock.
    input  wire logic       clk,
    // Pins towards the port.
    output var  logic [8:0] cmd_n,
    output var  logic [1:0] mem_sel
);
    // Command pins rest high between commands.
    initial
    begin
        cmd_n   = 9'h1ff;
        mem_sel = 2'h0;
    end

    // Presents a memory number and lets it settle past the filter.
    task automatic set_mem(input logic [1:0] m);
        mem_sel <= m;
        repeat (150) @(posedge clk);
    endtask

    // Pulls one command pin low, then releases it, each for 150 cycles.
    task automatic press(input int i);
        cmd_n[i] <= 1'b0;
        repeat (150) @(posedge clk);
        cmd_n[i] <= 1'b1;
        repeat (150) @(posedge clk);
    endtask
endmodule // ecp_ctl_model
`default_nettype wire

// ---- verification/ecp_port_tb.sv ----
// Self-checking testbench of the external control port.
`timescale 1ns/1ns
`default_nettype none
module ecp_port_tb
    import ecp_pkg::*;
;
    localparam int TW = 20;
    logic        clk, resetn, avs_read, avs_write, avs_waitrequest, clr;
    logic        pwr_p, out_p, prot_p, lim_p, gain_p, busy_p, rng_p;
    logic        trigger_pin, tlvl;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic [8:0]  cmd_n, st_pins;
    logic [1:0]  mem_sel, step_sync, recall_mem;
    logic [9:0]  cmd_strobe, seen;
    int          failures, total_checks, nstb, tcnt, cyc;

    assign st_pins = {step_sync, rng_p, busy_p, gain_p, lim_p, prot_p,
                      out_p, pwr_p};

    ecp_ctl_model ctl (.clk(clk), .cmd_n(cmd_n), .mem_sel(mem_sel));

    ecp_port #(.TRIG_WIDTH_RST(TW)) DUT
    (
        .clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .out_off_n(cmd_n[0]), .out_on_n(cmd_n[1]), .seq_start_n(cmd_n[2]),
        .seq_stop_n(cmd_n[3]), .seq_hold_n(cmd_n[4]),
        .branch1_n(cmd_n[5]), .branch2_n(cmd_n[6]), .recall_n(cmd_n[7]),
        .peak_clear_n(cmd_n[8]), .mem_sel(mem_sel),
        .power_state_pin(pwr_p), .output_state_pin(out_p),
        .protection_pin(prot_p), .limiter_pin(lim_p),
        .gain_correction_state_pin(gain_p), .busy_pin(busy_p),
        .range_pin(rng_p), .step_sync(step_sync),
        .trigger_pin(trigger_pin), .cmd_strobe(cmd_strobe),
        .recall_mem(recall_mem)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Collects strobes and active trigger cycles since the last clear.
    always @(posedge clk)
    begin
        if (clr)
        begin
            seen <= 10'h000;
            nstb <= 0;
            tcnt <= 0;
        end
        else
        begin
            seen <= seen | cmd_strobe;
            nstb <= nstb + $countones(cmd_strobe);
            tcnt <= tcnt + int'(trigger_pin === tlvl);
        end
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        total_checks = total_checks + 1;
        if (a !== e)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(e, rdat);
    endtask

    task automatic ctrl(input logic [1:0] md, input logic pol, tpol, rmt,
                        input logic [1:0] fn);
        bus(1'b1, ECP_CTRL_OFS, {25'h0, fn, rmt, tpol, pol, md});
    endtask

    task automatic clear();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    // Presses one command pin and compares the strobes it produced.
    task automatic cmd(input int i, input logic [9:0] e);
        clear();
        ctl.press(i);
        chk(e, seen);
        chk($countones(e), nstb);
    endtask

    function automatic logic [8:0] exp_pins(input logic [8:0] s,
                                            input logic p);
        return {s[8:6], s[5:1] ^ {5{!p}}, s[0]};
    endfunction

    task automatic t_reset();
        chk(9'h03e, st_pins);
        chk(1'b1, trigger_pin);
        rd_chk(ECP_CTRL_OFS, 32'h0);
        rd_chk(ECP_TWIDTH_OFS, TW);
        rd_chk(8'h18, 32'h0);
    endtask

    task automatic t_ignore();
        ctrl(ECP_MODE_DISABLE, 1'b0, 1'b0, 1'b0, ECP_FN_CONT);
        cmd(ECP_EV_ON, 10'h000);
        ctrl(ECP_MODE_ENABLE, 1'b0, 1'b0, 1'b1, ECP_FN_CONT);
        cmd(ECP_EV_ON, 10'h000);
        ctrl(ECP_MODE_TESTER, 1'b0, 1'b0, 1'b0, ECP_FN_CONT);
        cmd(ECP_EV_ON, 10'h000);
    endtask

    task automatic t_cmds();
        ctrl(ECP_MODE_ENABLE, 1'b0, 1'b0, 1'b0, ECP_FN_CONT);
        for (int i = 0; i < ECP_NCMD; i++)
            cmd(i, 10'h001 << i);
        rd_chk(ECP_EVENT_OFS, 32'h1ff);
        bus(1'b1, ECP_EVENT_OFS, 32'h3ff);
        rd_chk(ECP_EVENT_OFS, 32'h0);
    endtask

    task automatic t_recall();
        logic [9:0] e;
        for (int f = 0; f < 3; f++)
            for (int m = 0; m < 4; m++)
            begin
                ctrl(ECP_MODE_ENABLE, 1'b0, 1'b0, 1'b0, f[1:0]);
                ctl.set_mem(m[1:0]);
                rd_chk(ECP_PINS_OFS, {21'h0, m[1:0], 9'h1ff});
                e = (f != 0) ? 10'h280 : 10'h080;
                cmd(ECP_EV_RECALL, e);
                chk(m[1:0], recall_mem);
                rd_chk(ECP_EVENT_OFS, {f[1:0], m[1:0], e});
                bus(1'b1, ECP_EVENT_OFS, 32'h3ff);
            end
    endtask

    task automatic t_status();
        logic [8:0] s;
        for (int p = 0; p < 2; p++)
        begin
            ctrl(ECP_MODE_DISABLE, p[0], 1'b0, 1'b0, ECP_FN_CONT);
            for (int b = 0; b < 10; b++)
            begin
                s = (b == 9) ? 9'h180 : 9'h001 << b;
                bus(1'b1, ECP_STATE_OFS, {23'h0, s});
                @(posedge clk);
                chk(exp_pins(s, p[0]), st_pins);
                chk(s[8:7], step_sync);
            end
        end
    endtask

    task automatic t_trig();
        ctrl(ECP_MODE_ENABLE, 1'b0, 1'b1, 1'b0, ECP_FN_CONT);
        tlvl <= 1'b1;
        bus(1'b1, ECP_TWIDTH_OFS, 32'h5);
        clear();
        bus(1'b1, ECP_TCMD_OFS, 32'h1);
        repeat (20) @(posedge clk);
        chk(5, tcnt);
        ctrl(ECP_MODE_ENABLE, 1'b0, 1'b0, 1'b0, ECP_FN_CONT);
        tlvl <= 1'b0;
        bus(1'b1, ECP_TWIDTH_OFS, 32'h8);
        clear();
        bus(1'b1, ECP_TCMD_OFS, 32'h1);
        bus(1'b1, ECP_TCMD_OFS, 32'h1);
        rd_chk(ECP_TCMD_OFS, 32'h1);
        repeat (20) @(posedge clk);
        chk(11, tcnt);
    endtask

    initial
    begin
        resetn        = 1'b0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_address   = 8'h00;
        avs_writedata = 32'h0;
        clr           = 1'b1;
        tlvl          = 1'b1;
        failures      = 0;
        total_checks  = 0;
        cyc           = 0;
        repeat (8) @(posedge clk);
        chk(9'h03e, st_pins);
        chk(1'b1, avs_waitrequest);
        chk(10'h000, cmd_strobe);
        resetn <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        t_reset();
        t_ignore();
        t_cmds();
        t_recall();
        t_status();
        t_trig();
        final_report();
    end
endmodule // ecp_port_tb
`default_nettype wire
